// ### logic/pfm_page_fail.sv
// pfm_page_fail: refill mapping builder, page fail word encoder, trap sequencer, map probe
// assumes one request at a time from the core, memory port answers with mem_ack_i
`timescale 1ns/1ps
`include "pfm_regs.svh"

module pfm_page_fail
  import pfm_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reference request from the core
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire pfm_kind_t   req_kind_i,
  input  wire logic        req_probe_i,
  input  wire logic        req_user_i,
  input  wire logic        req_write_i,
  input  wire logic        req_phys_i,
  input  wire logic        req_byte_i,
  input  wire logic        req_intr_i,
  input  wire logic [21:0] req_addr_i,
  // pointer evaluation summary
  input  wire logic        eval_done_i,
  input  wire logic [2:0]  eval_type_i,
  input  wire logic        eval_w_i,
  input  wire logic        eval_c_i,
  input  wire logic        eval_mod_i,
  input  wire logic [9:0]  eval_page_i,
  input  wire logic [35:0] bad_word_i,
  // state of the interrupted program
  input  wire logic [17:0] cpu_flags_i,
  input  wire logic [17:0] cpu_pc_i,
  input  wire logic        trap_ret_i,
  input  wire logic        first_done_i,
  // mapping and status results
  output logic             map_valid_o,
  output logic             map_c_o,
  output logic             map_m_o,
  output logic             map_w_o,
  output logic      [9:0]  map_page_o,
  output logic             cst_set_m_o,
  output logic             abort_o,
  output logic             probe_done_o,
  output logic      [35:0] probe_word_o,
  output logic             halt_o,
  output logic             pc_load_o,
  output logic      [17:0] new_pc_o,
  output logic             flags_clear_o,
  output logic             restart_o,
  output logic             resume2_o,
  output logic             bad_mem_o,
  output logic             no_mem_o,
  // memory port for the trap
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [19:0] mem_addr_o,
  output logic      [35:0] mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [35:0] mem_rdata_i,
  // accumulator write port
  output logic             ac_we_o,
  output logic      [6:0]  ac_addr_o,
  output logic      [35:0] ac_wdata_o
);

  pfm_regs_t r_q;
  pfm_regs_t r_d;

  logic        take;
  logic        apb_wr;
  logic        apb_setup;
  logic        illegal_ptr;
  logic        soft_fail;
  logic        wr_viol;
  logic        dirty;
  logic [35:0] hard_word;
  logic [35:0] soft_word;
  logic [35:0] acc_word;
  logic [35:0] inacc_word;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic        fail_word_io;

  // requests only land while the sequencer rests; the core must hold them
  assign take        = req_valid_i && r_q.st == ST_IDLE;
  assign req_ready_o = r_q.st == ST_IDLE;
  assign apb_setup   = psel && !penable;
  assign apb_wr      = psel && penable && pwrite;

  // evaluation outcome classes
  assign illegal_ptr = eval_type_i[2];
  assign soft_fail   = !eval_done_i || illegal_ptr;
  assign wr_viol     = !soft_fail && req_write_i && !eval_w_i;
  assign dirty       = eval_w_i && (req_write_i || eval_mod_i);

  // hard word: memory format, or io format with bits 8 and 10 forced
  always_comb begin
    hard_word = 36'h0_0000_0000;
    hard_word[`PFM_FW_USER] = req_user_i;
    hard_word[`PFM_FW_HARD] = 1'b1;
    if (req_kind_i == KIND_IO) begin
      hard_word[`PFM_FW_CODE_HI:`PFM_FW_CODE_LO] = `PFM_CODE_IO;
      hard_word[`PFM_FW_PHYS] = 1'b1;
      hard_word[`PFM_FW_IOFN] = 1'b1;
      hard_word[`PFM_FW_BYTE] = req_byte_i;
      hard_word[21:0] = req_addr_i;
    end else begin
      hard_word[`PFM_FW_CODE_HI:`PFM_FW_CODE_LO] =
        (req_kind_i == KIND_ECC) ? `PFM_CODE_ECC : `PFM_CODE_NXM;
      hard_word[`PFM_FW_PHYS] = req_phys_i;
      hard_word[17:0] = req_addr_i[17:0];
    end
  end

  // soft word: bit1 clear, bit8 means virtual, bit4 is the anded w (zero)
  always_comb begin
    soft_word = 36'h0_0000_0000;
    soft_word[`PFM_FW_USER]  = req_user_i;
    soft_word[`PFM_FW_DONE]  = wr_viol;
    soft_word[`PFM_FW_WRITE] = wr_viol ? eval_w_i : 1'b0;
    soft_word[`PFM_FW_TYPE]  = req_write_i;
    soft_word[`PFM_FW_PHYS]  = 1'b1;
    soft_word[17:0] = req_addr_i[17:0];
  end

  // probe words for reachable and unreachable pages
  always_comb begin
    acc_word = 36'h0_0000_0000;
    acc_word[`PFM_FW_USER]  = req_user_i;
    acc_word[`PFM_FW_DONE]  = 1'b1;
    acc_word[`PFM_FW_DIRTY] = dirty;
    acc_word[`PFM_FW_WRITE] = eval_w_i;
    acc_word[`PFM_FW_CACHE] = eval_c_i;
    acc_word[`PFM_FW_PHYS]  = 1'b1;
    acc_word[18:0] = {eval_page_i, req_addr_i[8:0]};
    inacc_word = 36'h0_0000_0000;
    inacc_word[`PFM_FW_USER] = req_user_i;
    inacc_word[`PFM_FW_PHYS] = 1'b1;
    inacc_word[17:0] = req_addr_i[17:0];
  end

  // apb read mux; unmapped offsets read zero with an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `PFM_OFF_CTRL:     rd_mux[0] = r_q.paging_en;
      `PFM_OFF_UBR:      rd_mux[10:0] = r_q.ubr;
      `PFM_OFF_FLAGS: begin
        rd_mux[`PFM_FLG_BADMEM] = r_q.bad_mem;
        rd_mux[`PFM_FLG_NOMEM]  = r_q.no_mem;
      end
      `PFM_OFF_FAIL_LO:  rd_mux = r_q.fail_word[31:0];
      `PFM_OFF_FAIL_HI:  rd_mux[3:0] = r_q.fail_word[35:32];
      `PFM_OFF_PROBE_LO: rd_mux = r_q.probe_word[31:0];
      `PFM_OFF_PROBE_HI: rd_mux[3:0] = r_q.probe_word[35:32];
      `PFM_OFF_STATE: begin
        rd_mux[0] = r_q.st == ST_HALT;
        rd_mux[1] = r_q.st != ST_IDLE;
      end
      default:           rd_hit = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb begin
    r_d = r_q;
    r_d.map_valid   = 1'b0;
    r_d.cst_set_m   = 1'b0;
    r_d.abort       = 1'b0;
    r_d.probe_done  = 1'b0;
    r_d.pc_load     = 1'b0;
    r_d.flags_clear = 1'b0;
    r_d.restart     = 1'b0;
    r_d.resume2     = 1'b0;
    r_d.ac_we       = 1'b0;
    // apb: data captured in setup so the access phase answers at once
    if (apb_setup) begin
      r_d.prdata  = rd_mux;
      r_d.pslverr = !rd_hit;
    end
    if (apb_wr) begin
      if (paddr == `PFM_OFF_CTRL) r_d.paging_en = pwdata[0];
      if (paddr == `PFM_OFF_UBR)  r_d.ubr = pwdata[10:0];
      if (paddr == `PFM_OFF_FLAGS) begin
        if (pwdata[`PFM_FLG_BADMEM]) r_d.bad_mem = 1'b0;
        if (pwdata[`PFM_FLG_NOMEM])  r_d.no_mem = 1'b0;
      end
    end
    // restored flags pick where the failed instruction picks up
    if (trap_ret_i && r_q.st == ST_IDLE) begin
      r_d.restart = !first_done_i;
      r_d.resume2 = first_done_i;
    end
    case (r_q.st)
      ST_IDLE: begin
        if (take) begin
          r_d.save_fpc = {cpu_flags_i, cpu_pc_i};
          r_d.bad_word = bad_word_i;
          if (req_probe_i) begin
            // probe never traps; every outcome lands in the probe word
            r_d.probe_done = 1'b1;
            if (!r_q.paging_en)
              r_d.probe_word = 36'h0_0000_0000;
            else if (req_kind_i == KIND_ECC || req_kind_i == KIND_NXM)
              r_d.probe_word = hard_word;
            else if (soft_fail)
              r_d.probe_word = inacc_word;
            else
              r_d.probe_word = acc_word;
          end else if (req_kind_i == KIND_REFILL && !soft_fail && !wr_viol) begin
            r_d.map_valid = 1'b1;
            r_d.map_c     = eval_c_i;
            r_d.map_m     = dirty;
            r_d.map_w     = eval_w_i;
            r_d.map_page  = eval_page_i;
            r_d.cst_set_m = dirty;
          end else begin
            r_d.abort     = 1'b1;
            r_d.fail_word = (req_kind_i == KIND_REFILL) ? soft_word : hard_word;
            if (req_kind_i == KIND_ECC) r_d.bad_mem = 1'b1;
            if (req_kind_i == KIND_NXM) r_d.no_mem = 1'b1;
            if (req_intr_i)
              r_d.st = ST_HALT;
            else if (req_kind_i == KIND_ECC)
              r_d.st = ST_AC0;
            else
              r_d.st = ST_W500;
          end
        end
      end
      ST_AC0: begin
        r_d.ac_we    = 1'b1;
        r_d.ac_addr  = {`PFM_AC_BLOCK, `PFM_AC_SLOT0};
        r_d.ac_wdata = r_q.bad_word;
        r_d.st       = ST_AC1;
      end
      ST_AC1: begin
        r_d.ac_we    = 1'b1;
        r_d.ac_addr  = {`PFM_AC_BLOCK, `PFM_AC_SLOT1};
        r_d.ac_wdata = r_q.bad_word;
        r_d.st       = ST_W500;
      end
      ST_W500: begin
        r_d.mem_req   = 1'b1;
        r_d.mem_we    = 1'b1;
        r_d.mem_addr  = {r_q.ubr, `PFM_LOC_FAIL};
        r_d.mem_wdata = r_q.fail_word;
        if (r_q.mem_req && mem_ack_i) begin
          r_d.mem_addr  = {r_q.ubr, `PFM_LOC_FPC};
          r_d.mem_wdata = {r_q.save_fpc[35:18], 18'h0_0000};
          r_d.st        = ST_W501;
        end
      end
      ST_W501: begin
        if (mem_ack_i) begin
          r_d.mem_addr  = {r_q.ubr, `PFM_LOC_PC};
          r_d.mem_wdata = {18'h0_0000, r_q.save_fpc[17:0]};
          r_d.st        = ST_W502;
        end
      end
      ST_W502: begin
        if (mem_ack_i) begin
          r_d.mem_we    = 1'b0;
          r_d.mem_addr  = {r_q.ubr, `PFM_LOC_NEWPC};
          r_d.mem_wdata = 36'h0_0000_0000;
          r_d.st        = ST_R503;
        end
      end
      ST_R503: begin
        if (mem_ack_i) begin
          r_d.mem_req     = 1'b0;
          r_d.new_pc      = mem_rdata_i[17:0];
          r_d.pc_load     = 1'b1;
          r_d.flags_clear = 1'b1;
          r_d.st          = ST_IDLE;
        end
      end
      ST_HALT: r_d.st = ST_HALT;                                          // only reset leaves
      default: r_d.st = ST_IDLE;
    endcase
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q           <= '0;
      r_q.st        <= ST_IDLE;
      r_q.paging_en <= `PFM_RST_CTRL;
      r_q.ubr       <= `PFM_RST_UBR;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs from the state record; pready tied high, pslverr gated by the access phase
  assign prdata        = r_q.prdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && r_q.pslverr;
  assign map_valid_o   = r_q.map_valid;
  assign map_c_o       = r_q.map_c;
  assign map_m_o       = r_q.map_m;
  assign map_w_o       = r_q.map_w;
  assign map_page_o    = r_q.map_page;
  assign cst_set_m_o   = r_q.cst_set_m;
  assign abort_o       = r_q.abort;
  assign probe_done_o  = r_q.probe_done;
  assign probe_word_o  = r_q.probe_word;
  assign halt_o        = r_q.st == ST_HALT;
  assign pc_load_o     = r_q.pc_load;
  assign new_pc_o      = r_q.new_pc;
  assign flags_clear_o = r_q.flags_clear;
  assign restart_o     = r_q.restart;
  assign resume2_o     = r_q.resume2;
  assign bad_mem_o     = r_q.bad_mem;
  assign no_mem_o      = r_q.no_mem;
  assign mem_req_o     = r_q.mem_req;
  assign mem_we_o      = r_q.mem_we;
  assign mem_addr_o    = r_q.mem_addr;
  assign mem_wdata_o   = r_q.mem_wdata;
  assign ac_we_o       = r_q.ac_we;
  assign ac_addr_o     = r_q.ac_addr;
  assign ac_wdata_o    = r_q.ac_wdata;

  // checks on the produced behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fail_take;
    take && !req_probe_i && !req_intr_i && (req_kind_i != KIND_REFILL || soft_fail || wr_viol);
  endsequence

  sequence s_store500;
    mem_req_o && mem_we_o && mem_addr_o[8:0] == 9'h140;
  endsequence

  map_valid_one_a: assert property (map_valid_o |-> map_page_o == $past(eval_page_i))
    else $error("mapping page differs from evaluation");
  map_cache_and_a: assert property (take && !req_probe_i && req_kind_i == KIND_REFILL && !soft_fail
    && !wr_viol |=> map_valid_o && map_c_o == $past(eval_c_i))
    else $error("refill mapping or cacheable bit wrong");
  map_dirty_a: assert property (map_valid_o |-> map_m_o == (map_w_o && $past(req_write_i || eval_mod_i))
    && cst_set_m_o == map_m_o)
    else $error("dirty bit or status update wrong");
  write_prot_a: assert property (take && !req_probe_i && req_kind_i == KIND_REFILL && eval_done_i
    && !illegal_ptr && req_write_i && !eval_w_i |=> abort_o && !map_valid_o)
    else $error("write to protected page not failed");
  fail_abort_a: assert property (s_fail_take |=> abort_o ##1 !pc_load_o)
    else $error("failure did not abort");
  trap_seq_a: assert property (s_fail_take |-> if (req_kind_i == KIND_ECC) ##4 s_store500
    else ##2 s_store500)
    else $error("fail word store did not start");
  io_trap_a: assert property (take && !req_probe_i && !req_intr_i && req_kind_i == KIND_IO
    |=> fail_word_io)
    else $error("io failure not trapped");
  intr_halt_a: assert property (take && !req_probe_i && req_intr_i
    && (req_kind_i != KIND_REFILL || soft_fail || wr_viol) |=> halt_o [*4])
    else $error("interrupt failure did not halt");
  hard_word_a: assert property (abort_o && r_q.fail_word[`PFM_FW_HARD]
    |-> r_q.fail_word[`PFM_FW_CODE_HI:`PFM_FW_CODE_LO] >= 5'h10)
    else $error("hard code below twenty");
  soft_word_a: assert property (abort_o && !r_q.fail_word[`PFM_FW_HARD]
    |-> r_q.fail_word[`PFM_FW_PHYS] && !r_q.fail_word[`PFM_FW_WRITE])
    else $error("soft word layout wrong");
  ecc_flag_a: assert property (take && !req_probe_i && !req_intr_i && req_kind_i == KIND_ECC
    |=> bad_mem_o ##1 ac_we_o && ac_addr_o == 7'h70)
    else $error("ecc flag or ac save missing");
  probe_free_a: assert property (take && req_probe_i |=> probe_done_o && !abort_o && !mem_req_o)
    else $error("probe raised a trap");
  resume_a: assert property (trap_ret_i && r_q.st == ST_IDLE |=> restart_o != resume2_o)
    else $error("trap return choice missing");
  assign fail_word_io = abort_o && r_q.fail_word[`PFM_FW_CODE_HI:`PFM_FW_CODE_LO] == `PFM_CODE_IO
                        && r_q.fail_word[`PFM_FW_IOFN];

endmodule // pfm_page_fail

// ### include/pfm_regs.svh
// pfm_regs.svh: offsets, fail word field positions, trap locations, reset values
// assumes 36-bit words held as [35:0], machine bit n sits at index 35-n
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH
// apb register byte offsets
`define PFM_OFF_CTRL     12'h000
`define PFM_OFF_UBR      12'h004
`define PFM_OFF_FLAGS    12'h008
`define PFM_OFF_FAIL_LO  12'h00C
`define PFM_OFF_FAIL_HI  12'h010
`define PFM_OFF_PROBE_LO 12'h014
`define PFM_OFF_PROBE_HI 12'h018
`define PFM_OFF_STATE    12'h01C
// reset values
`define PFM_RST_CTRL     1'h0
`define PFM_RST_UBR      11'h000
// processor flag positions (machine bits 28 and 27) in the flag read word
`define PFM_FLG_BADMEM   7
`define PFM_FLG_NOMEM    8
// fail word and probe word fields
`define PFM_FW_USER      35
`define PFM_FW_HARD      34
`define PFM_FW_CODE_HI   34
`define PFM_FW_CODE_LO   30
`define PFM_FW_DONE      33
`define PFM_FW_DIRTY     32
`define PFM_FW_WRITE     31
`define PFM_FW_TYPE      30
`define PFM_FW_CACHE     28
`define PFM_FW_PHYS      27
`define PFM_FW_IOFN      25
`define PFM_FW_BYTE      22
// hard failure codes
`define PFM_CODE_IO      5'h10
`define PFM_CODE_ECC     5'h1E
`define PFM_CODE_NXM     5'h1F
// process table trap locations
`define PFM_LOC_FAIL     9'h140
`define PFM_LOC_FPC      9'h141
`define PFM_LOC_PC       9'h142
`define PFM_LOC_NEWPC    9'h143
// ac block and slots used to park an uncorrectable word
`define PFM_AC_BLOCK     3'h7
`define PFM_AC_SLOT0     4'h0
`define PFM_AC_SLOT1     4'h1
`endif

// ### include/pfm_pkg.sv
// pfm_pkg: state, request kinds and the module state record
// assumes pfm_regs.svh supplies every number
package pfm_pkg;
  typedef enum logic [2:0] {
    KIND_REFILL, KIND_ECC, KIND_NXM, KIND_IO
  } pfm_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_AC0, ST_AC1, ST_W500, ST_W501, ST_W502, ST_R503, ST_HALT
  } pfm_state_t;

  typedef struct packed {
    pfm_state_t  st;
    logic        paging_en;
    logic [10:0] ubr;
    logic        bad_mem;
    logic        no_mem;
    logic [35:0] fail_word;
    logic [35:0] probe_word;
    logic        map_valid;
    logic        map_c;
    logic        map_m;
    logic        map_w;
    logic [9:0]  map_page;
    logic        cst_set_m;
    logic        abort;
    logic        probe_done;
    logic        pc_load;
    logic [17:0] new_pc;
    logic        flags_clear;
    logic        restart;
    logic        resume2;
    logic        mem_req;
    logic        mem_we;
    logic [19:0] mem_addr;
    logic [35:0] mem_wdata;
    logic        ac_we;
    logic [6:0]  ac_addr;
    logic [35:0] ac_wdata;
    logic [35:0] bad_word;
    logic [35:0] save_fpc;
    logic [31:0] prdata;
    logic        pslverr;
  } pfm_regs_t;
endpackage

// ### dv/pfm_bus_model.sv
// pfm_bus_model: memory side of the page fail trap, answers each request after lat cycles
// assumes the design holds mem_req_o and its address until mem_ack
`timescale 1ns/1ps
module pfm_bus_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [19:0] mem_addr,
  input  wire logic [35:0] mem_wdata,
  output logic             mem_ack,
  output logic      [35:0] mem_rdata,
  // answer delay in cycles
  input  wire logic [3:0]  lat
);
  localparam logic [35:0] NEW_PC = 36'h0_0000_1234;
  logic [35:0] mem [0:3];
  logic [3:0]  cnt;
  // data only valid with ack; inverted otherwise so stale data never passes
  assign mem_rdata = mem_ack ? NEW_PC : ~NEW_PC;
  // one ack per request, never on the address the design just left
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt     <= 4'h0;
    end else if (mem_req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt     <= 4'h0;
      if (mem_we) begin
        mem[mem_addr[1:0]] <= mem_wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      cnt     <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // pfm_bus_model

// ### dv/tb_page_fail_and_map_probe.sv
// tb_page_fail_and_map_probe: directed scenarios for refill, fail words, trap, probe, halt
// assumes pfm_bus_model answers the trap memory port
`timescale 1ns/1ps
`include "pfm_regs.svh"
module tb_page_fail_and_map_probe
  import pfm_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        req_valid_i, req_ready_o, req_probe_i, req_user_i, req_write_i, req_phys_i;
  logic        req_byte_i, req_intr_i, eval_done_i, eval_w_i, eval_c_i, eval_mod_i;
  pfm_kind_t   req_kind_i;
  logic [21:0] req_addr_i;
  logic [2:0]  eval_type_i;
  logic [9:0]  eval_page_i, map_page_o;
  logic [35:0] bad_word_i, probe_word_o, mem_wdata_o, mem_rdata_i, ac_wdata_o;
  logic [17:0] cpu_flags_i, cpu_pc_i, new_pc_o;
  logic        trap_ret_i, first_done_i, map_valid_o, map_c_o, map_m_o, cst_set_m_o, abort_o;
  logic        halt_o, pc_load_o, flags_clear_o, restart_o, resume2_o, bad_mem_o, no_mem_o;
  logic        mem_req_o, mem_we_o, mem_ack_i, ac_we_o, map_w_o, probe_done_o;
  logic [19:0] mem_addr_o;
  logic [6:0]  ac_addr_o;
  logic [3:0]  lat;
  int          err_count, num_checks;

  pfm_page_fail i_pfm_page_fail (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .req_valid_i, .req_ready_o, .req_kind_i, .req_probe_i, .req_user_i,
    .req_write_i, .req_phys_i, .req_byte_i, .req_intr_i, .req_addr_i, .eval_done_i, .eval_type_i,
    .eval_w_i, .eval_c_i, .eval_mod_i, .eval_page_i, .bad_word_i, .cpu_flags_i, .cpu_pc_i,
    .trap_ret_i, .first_done_i, .map_valid_o, .map_c_o, .map_m_o, .map_w_o, .map_page_o,
    .cst_set_m_o, .abort_o, .probe_done_o, .probe_word_o, .halt_o, .pc_load_o, .new_pc_o,
    .flags_clear_o, .restart_o, .resume2_o, .bad_mem_o, .no_mem_o, .mem_req_o, .mem_we_o,
    .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .ac_we_o, .ac_addr_o, .ac_wdata_o);

  pfm_bus_model i_pfm_bus_model (.pclk, .presetn, .mem_req(mem_req_o), .mem_we(mem_we_o),
    .mem_addr(mem_addr_o), .mem_wdata(mem_wdata_o), .mem_ack(mem_ack_i), .mem_rdata(mem_rdata_i), .lat);

  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task summarize;
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // apb master: setup, access held until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // request fields {probe,user,write,phys,byte,intr,done,w,c,mod}; held until taken
  task automatic rq(input pfm_kind_t k, input logic [9:0] f, input logic [2:0] t, input logic [21:0] a);
    @(posedge pclk);
    req_kind_i  <= k;
    eval_type_i <= t;
    req_addr_i  <= a;
    {req_probe_i, req_user_i, req_write_i, req_phys_i, req_byte_i, req_intr_i,
     eval_done_i, eval_w_i, eval_c_i, eval_mod_i} <= f;
    req_valid_i <= 1'b1;
    do @(posedge pclk); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    #1;
  endtask

  // trap must end with new pc loaded; fail word and flag-pc pair in the process table
  task automatic trap(input logic [35:0] e);
    for (int i = 0; i < 80 && pc_load_o !== 1'b1; i++) @(posedge pclk) #1;
    chk("new pc", new_pc_o, 18'h0_1234);
    chk("flags clear", flags_clear_o, 1);
    chk("flag word", i_pfm_bus_model.mem[1], {18'h2_8000, 18'h0});
    chk("pc word", i_pfm_bus_model.mem[2], {18'h0, 18'h0_0777});
    chk("fail word", i_pfm_bus_model.mem[0], e);
  endtask

  task t_regs;
    apb(1'b0, `PFM_OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, 36'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", sl, 1);
    apb(1'b1, `PFM_OFF_CTRL, 32'h0000_0001);
    apb(1'b0, `PFM_OFF_CTRL, 32'h0);
    chk("paging on", rd, 36'h1);
  endtask

  task t_refill;
    rq(KIND_REFILL, 10'b0000001100, 3'h1, 22'h00_0100);
    chk("valid", {map_valid_o, map_w_o}, 2'b11);
    chk("c and", map_c_o, 0);
    chk("m read", map_m_o, 0);
    rq(KIND_REFILL, 10'b0010001110, 3'h2, 22'h00_0200);
    chk("m write", {map_m_o, cst_set_m_o, map_c_o}, 3'b111);
    chk("page", map_page_o, 10'h2A5);
    rq(KIND_REFILL, 10'b0000001111, 3'h3, 22'h00_0300);
    chk("m modified", map_m_o, 1);
  endtask

  task t_soft;
    lat <= 4'h2;
    rq(KIND_REFILL, 10'b0110001010, 3'h1, 22'h02_0345);
    chk("abort", {abort_o, map_valid_o}, 2'b10);
    chk("no store", mem_we_o && mem_addr_o[8:0] != 9'h140, 0);
    trap({6'b101001, 2'b0, 1'b1, 9'h0, 18'h2_0345});
    rq(KIND_REFILL, 10'b0010001100, 3'h5, 22'h00_1200);
    trap({6'b000001, 2'b0, 1'b1, 9'h0, 18'h0_1200});
    rq(KIND_REFILL, 10'b0100000100, 3'h1, 22'h00_2200);
    trap({6'b100000, 2'b0, 1'b1, 9'h0, 18'h0_2200});
  endtask

  task t_hard;
    lat <= 4'h0;
    rq(KIND_ECC, 10'b0100000000, 3'h1, 22'h03_0001);
    @(posedge pclk) #1;
    chk("ac park", {ac_we_o, ac_addr_o}, 8'hF0);
    chk("ac word", ac_wdata_o, 36'h5_A5A5_A5A5);
    trap({1'b1, 5'o36, 2'b0, 1'b0, 9'h0, 18'h3_0001});
    chk("bad mem", bad_mem_o, 1);
    rq(KIND_NXM, 10'b0001000000, 3'h1, 22'h00_0042);
    trap({1'b0, 5'o37, 2'b0, 1'b1, 9'h0, 18'h0_0042});
    apb(1'b0, `PFM_OFF_FLAGS, 32'h0);
    chk("flag reg", rd[8:7], 2'b11);
    rq(KIND_IO, 10'b0000100000, 3'h1, 22'h2A_BCDE);
    trap({6'o20, 5'b00101, 2'b0, 1'b1, 22'h2A_BCDE});
  endtask

  task t_probe;
    rq(KIND_REFILL, 10'b1100001110, 3'h1, 22'h00_4567);
    chk("probe ok", probe_word_o, {9'b101010011, 8'h0, 10'h2A5, 9'h167});
    chk("probe no trap", abort_o, 0);
    chk("probe done", probe_done_o, 1);
    rq(KIND_REFILL, 10'b1000000000, 3'h1, 22'h00_4567);
    chk("probe miss", probe_word_o, {8'h0, 1'b1, 9'h0, 18'h0_4567});
    rq(KIND_ECC, 10'b1000000000, 3'h1, 22'h00_0123);
    chk("probe err abort", abort_o, 0);
    chk("probe err", probe_word_o, {6'o36, 2'b0, 1'b0, 9'h0, 18'h0_0123});
  endtask

  // software has invalidated the mapping before returning
  task t_ret;
    @(posedge pclk);
    first_done_i <= 1'b1;
    trap_ret_i   <= 1'b1;
    @(posedge pclk);
    trap_ret_i <= 1'b0;
    #1;
    chk("resume second", resume2_o, 1);
    @(posedge pclk);
    first_done_i <= 1'b0;
    trap_ret_i   <= 1'b1;
    @(posedge pclk);
    trap_ret_i <= 1'b0;
    #1;
    chk("restart", {restart_o, resume2_o}, 2'b10);
  endtask

  task t_halt;
    rq(KIND_REFILL, 10'b0010011000, 3'h1, 22'h00_0500);
    repeat (3) @(posedge pclk);
    #1;
    chk("halt", {halt_o, mem_req_o, req_ready_o}, 3'b100);
    apb(1'b0, `PFM_OFF_STATE, 32'h0);
    chk("halt state", rd[1:0], 2'b11);
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // watchdog well past the 140 or so cycles the scenarios take
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    summarize;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, req_valid_i, trap_ret_i, first_done_i} = '0;
    {req_probe_i, req_user_i, req_write_i, req_phys_i, req_byte_i, req_intr_i} = '0;
    {eval_done_i, eval_w_i, eval_c_i, eval_mod_i, eval_type_i, req_addr_i} = '0;
    req_kind_i  = KIND_REFILL;
    eval_page_i = 10'h2A5;
    bad_word_i  = 36'h5_A5A5_A5A5;
    cpu_flags_i = 18'h2_8000;
    cpu_pc_i    = 18'h0_0777;
    lat         = 4'h0;
    presetn     = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_refill;
    t_soft;
    t_hard;
    t_probe;
    t_ret;
    t_halt;
    summarize;
  end
endmodule // tb_page_fail_and_map_probe
